// ---- src/gpio_pkg.sv ----
// Shared constants and types for the general-purpose port block
package gpio_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PORT_COUNT = 7;
  localparam int PORT_W = 8;
  localparam int SMALL_PKG_PORTS = 5;

  typedef logic [7:0] byte_t;
  typedef logic [PORT_COUNT-1:0][PORT_W-1:0] port_bus_t;
  typedef logic [PORT_COUNT-1:0] port_mask_t;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam byte_t PORT0_DATA_ADDR = 8'h80;
  localparam byte_t PORT1_DATA_ADDR = 8'h90;
  localparam byte_t PORT2_DATA_ADDR = 8'hA0;
  localparam byte_t PORT3_DATA_ADDR = 8'hB0;
  localparam byte_t PORT4_DATA_ADDR = 8'hC0;
  localparam byte_t PORT5_DATA_ADDR = 8'h98;
  localparam byte_t PORT6_DATA_ADDR = 8'hC8;
  localparam byte_t INPUT_GATE_ADDR = 8'hF7;
  localparam byte_t PORT_ADDR [PORT_COUNT] = '{
    PORT0_DATA_ADDR, PORT1_DATA_ADDR, PORT2_DATA_ADDR, PORT3_DATA_ADDR,
    PORT4_DATA_ADDR, PORT5_DATA_ADDR, PORT6_DATA_ADDR};

  // Bit-addressable area and bit-address split
  localparam int BIT_SEL_W = 3;
  localparam int SFR_AREA_BIT = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam byte_t PORT_LATCH_RST = 8'hFF;
  localparam port_mask_t INPUT_GATE_RST = 7'h7F;
  localparam logic DIR_INPUT = 1'b1;

  // ----------------------------------------------------------------
  // Opcodes that the block must classify
  // ----------------------------------------------------------------
  localparam byte_t OP_ANL_DIR_A = 8'h52;
  localparam byte_t OP_ANL_DIR_IMM = 8'h53;
  localparam byte_t OP_ORL_DIR_A = 8'h42;
  localparam byte_t OP_ORL_DIR_IMM = 8'h43;
  localparam byte_t OP_XRL_DIR_A = 8'h62;
  localparam byte_t OP_XRL_DIR_IMM = 8'h63;
  localparam byte_t OP_JBC_BIT = 8'h10;
  localparam byte_t OP_CPL_BIT = 8'hB2;
  localparam byte_t OP_INC_DIR = 8'h05;
  localparam byte_t OP_DEC_DIR = 8'h15;
  localparam byte_t OP_DJNZ_DIR = 8'hD5;
  localparam byte_t OP_MOV_BIT_C = 8'h92;
  localparam byte_t OP_CLR_BIT = 8'hC2;
  localparam byte_t OP_SETB_BIT = 8'hD2;
  localparam byte_t OP_MOV_DIR_DIR = 8'h85;
  localparam byte_t OP_SFR_INDIRECT = 8'hA5;

  typedef enum {RD_IDLE, RD_STALL} rd_state_e;

endpackage

// ---- src/pin_sample_if.sv ----
// Carrier between the port core and its pin input sampler
`timescale 1ns/10ps
interface pin_sample_if;
  import gpio_pkg::*;

  port_bus_t raw;
  port_mask_t gate;
  port_bus_t sampled;

  modport core (output raw, output gate, input sampled);
  modport sampler (input raw, input gate, output sampled);
endinterface

// ---- src/pin_sampler.sv ----
// Three-stage pin synchroniser with agreement filter and input gate
`timescale 1ns/10ps
module pin_sampler #(
  parameter int PORTS = gpio_pkg::PORT_COUNT // ports actually bonded
) (
  input wire logic clk,          // system clock
  input wire logic srst,         // synchronous reset, active high
  pin_sample_if.sampler io       // raw pins in, gated samples out
);
  import gpio_pkg::*;

  port_bus_t stage1_ff;
  port_bus_t stage2_ff;
  port_bus_t stage3_ff;
  port_bus_t sampled_ff;

  assign io.sampled = sampled_ff;

  // ----------------------------------------------------------------
  // Per-port sampling
  // ----------------------------------------------------------------
  for (genvar g = 0; g < PORT_COUNT; g++) begin : g_port
    if (g < PORTS) begin : g_live
      always_ff @(posedge clk) begin
        if (srst) begin
          stage1_ff[g] <= '0;
          stage2_ff[g] <= '0;
          stage3_ff[g] <= '0;
        end else begin
          stage1_ff[g] <= io.raw[g];
          stage2_ff[g] <= stage1_ff[g];
          stage3_ff[g] <= stage2_ff[g];
        end
      end

      // While the gate is open, only bits where stages two and three agree may move
      always_ff @(posedge clk) begin
        if (srst) begin
          sampled_ff[g] <= '0;
        end else if (!io.gate[g]) begin
          sampled_ff[g] <= '0;
        end else begin
          sampled_ff[g] <= (stage2_ff[g] & ~(stage2_ff[g] ^ stage3_ff[g]))
                         | (sampled_ff[g] & (stage2_ff[g] ^ stage3_ff[g]));
        end
      end
    end else begin : g_absent
      always_ff @(posedge clk) begin
        stage1_ff[g] <= '0;
        stage2_ff[g] <= '0;
        stage3_ff[g] <= '0;
        sampled_ff[g] <= '0;
      end
    end
  end

endmodule

// ---- src/gpio_port_ctrl.sv ----
// Port latches, input gating and special-register access for the GPIO ports
`timescale 1ns/10ps
module gpio_port_ctrl #(
  parameter int PORTS = gpio_pkg::PORT_COUNT // 7 wide package, 5 small
) (
  input wire logic clk,                    // system clock, 20 MHz
  input wire logic srst,                   // synchronous reset, high
  input wire gpio_pkg::byte_t sfr_addr,    // byte or bit address
  input wire logic sfr_bit,                // address is a bit address
  input wire logic sfr_wr,                 // write strobe, one cycle
  input wire logic sfr_rd,                 // read strobe, one cycle
  input wire gpio_pkg::byte_t sfr_wdata,   // write data, bit ops use [0]
  input wire gpio_pkg::byte_t cpu_opcode,  // opcode of the access
  input wire logic dbg_active,             // debugger interrupt running
  output logic [7:0] sfr_rdata,            // read data
  output logic sfr_rvalid,                 // read answer strobe
  input wire gpio_pkg::port_bus_t port_dir, // 1 input, 0 output
  input wire gpio_pkg::port_bus_t pin_in,  // pin levels, asynchronous
  output gpio_pkg::port_bus_t pin_out,     // pin drive levels
  output gpio_pkg::port_bus_t pin_oe_n     // low while pin is driven
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (PORTS != PORT_COUNT && PORTS != SMALL_PKG_PORTS) begin : g_bad
    $error("PORTS must be 5 or 7");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // One-hot port select; ports not bonded never match
  function automatic port_mask_t port_hit(input byte_t a);
    port_mask_t m;
    m = '0;
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (i < PORTS && a == PORT_ADDR[i]) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Opcodes whose port operand is the latch, even when not read
  function automatic logic is_rmw(input byte_t op);
    logic r;
    r = 1'b0;
    case (op)
      OP_ANL_DIR_A, OP_ANL_DIR_IMM,
      OP_ORL_DIR_A, OP_ORL_DIR_IMM,
      OP_XRL_DIR_A, OP_XRL_DIR_IMM,
      OP_JBC_BIT, OP_CPL_BIT,
      OP_INC_DIR, OP_DEC_DIR, OP_DJNZ_DIR,
      OP_MOV_BIT_C, OP_CLR_BIT, OP_SETB_BIT: begin
        r = 1'b1;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // Reads that meet the synchronous debug memory need a spare cycle
  function automatic logic needs_stall(input byte_t op);
    return op == OP_MOV_DIR_DIR || op == OP_SFR_INDIRECT;
  endfunction

  // Bit addresses in the register area name the byte on an 8 boundary
  function automatic byte_t byte_of(input byte_t a, input logic b);
    byte_t r;
    r = a;
    if (b) begin
      r = {a[7:BIT_SEL_W], {BIT_SEL_W{1'b0}}};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  port_bus_t latch_ff;
  port_mask_t gate_ff;
  port_bus_t oe_n_ff;
  byte_t rdata_ff;
  logic rvalid_ff;
  rd_state_e rd_state_ff;
  rd_state_e nxt_rd_state;
  byte_t hold_addr_ff;
  logic hold_bit_ff;
  logic hold_rmw_ff;

  pin_sample_if samp ();

  assign samp.raw = pin_in;
  assign samp.gate = gate_ff;

  pin_sampler #(
    .PORTS(PORTS)
  ) u_sampler (
    .clk(clk),
    .srst(srst),
    .io(samp.sampler)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  byte_t wr_byte;
  port_mask_t wr_hit;
  logic wr_area;
  logic [BIT_SEL_W-1:0] wr_sel;

  always_comb begin
    wr_byte = byte_of(sfr_addr, sfr_bit);
    wr_area = sfr_addr[SFR_AREA_BIT];
    wr_sel = sfr_addr[BIT_SEL_W-1:0];
    wr_hit = '0;
    if (sfr_wr && (!sfr_bit || wr_area)) begin
      wr_hit = port_hit(wr_byte);
    end
  end

  // ----------------------------------------------------------------
  // Port latches
  // ----------------------------------------------------------------
  // The latch is what the pins drive, and modify writes land here
  for (genvar g = 0; g < PORT_COUNT; g++) begin : g_latch
    always_ff @(posedge clk) begin
      if (srst) begin
        latch_ff[g] <= PORT_LATCH_RST;
      end else if (wr_hit[g]) begin
        if (sfr_bit) begin
          latch_ff[g][wr_sel] <= sfr_wdata[0];
        end else begin
          latch_ff[g] <= sfr_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Input gate register
  // ----------------------------------------------------------------
  // Top bit is reserved and never stored, so it always reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      gate_ff <= INPUT_GATE_RST;
    end else if (sfr_wr && !sfr_bit && sfr_addr == INPUT_GATE_ADDR) begin
      gate_ff <= sfr_wdata[PORT_COUNT-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Absent ports stay undriven whatever their direction bits say
  for (genvar g = 0; g < PORT_COUNT; g++) begin : g_drive
    always_ff @(posedge clk) begin
      if (srst) begin
        oe_n_ff[g] <= {PORT_W{DIR_INPUT}};
      end else if (g < PORTS) begin
        oe_n_ff[g] <= port_dir[g];
      end else begin
        oe_n_ff[g] <= {PORT_W{DIR_INPUT}};
      end
    end
  end

  assign pin_out = latch_ff;
  assign pin_oe_n = oe_n_ff;

  // ----------------------------------------------------------------
  // Read sequencing
  // ----------------------------------------------------------------
  logic stall_req;

  assign stall_req = sfr_rd && dbg_active && needs_stall(cpu_opcode);

  always_comb begin
    nxt_rd_state = rd_state_ff;
    case (rd_state_ff)
      RD_IDLE: begin
        if (stall_req) begin
          nxt_rd_state = RD_STALL;
        end
      end
      RD_STALL: begin
        nxt_rd_state = RD_IDLE;
      end
      default: begin
        nxt_rd_state = RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_state_ff <= RD_IDLE;
    end else begin
      rd_state_ff <= nxt_rd_state;
    end
  end

  // Request held over the stall cycle; new reads then are ignored
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_addr_ff <= '0;
      hold_bit_ff <= 1'b0;
      hold_rmw_ff <= 1'b0;
    end else if (rd_state_ff == RD_IDLE && stall_req) begin
      hold_addr_ff <= sfr_addr;
      hold_bit_ff <= sfr_bit;
      hold_rmw_ff <= is_rmw(cpu_opcode);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  byte_t rd_addr;
  byte_t rd_byte;
  logic rd_bit;
  logic rd_rmw;
  port_mask_t rd_hit;
  byte_t rd_src;
  byte_t nxt_rdata;
  logic [BIT_SEL_W-1:0] rd_sel;

  always_comb begin
    if (rd_state_ff == RD_STALL) begin
      rd_addr = hold_addr_ff;
      rd_bit = hold_bit_ff;
      rd_rmw = hold_rmw_ff;
    end else begin
      rd_addr = sfr_addr;
      rd_bit = sfr_bit;
      rd_rmw = is_rmw(cpu_opcode);
    end
    rd_byte = byte_of(rd_addr, rd_bit);
    rd_sel = rd_addr[BIT_SEL_W-1:0];
    rd_hit = '0;
    if (!rd_bit || rd_addr[SFR_AREA_BIT]) begin
      rd_hit = port_hit(rd_byte);
    end
    rd_src = '0;
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (rd_hit[i]) begin
        // Latch for modify ops, gated pin sample otherwise
        rd_src = rd_rmw ? latch_ff[i] : samp.sampled[i];
      end
    end
    nxt_rdata = '0;
    if (rd_bit) begin
      nxt_rdata = {7'h00, rd_src[rd_sel]};
    end else if (rd_addr == INPUT_GATE_ADDR) begin
      nxt_rdata = {1'b0, gate_ff};
    end else begin
      nxt_rdata = rd_src;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
    end else if (rd_state_ff == RD_STALL) begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= 1'b1;
    end else if (sfr_rd && !stall_req) begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= 1'b1;
    end else begin
      rvalid_ff <= 1'b0;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign sfr_rvalid = rvalid_ff;

endmodule

// ---- verif/gpio_port_checker.sv ----
// Concurrent checks on the port controller's pins and register bus
`timescale 1ns/10ps
module gpio_port_checker #(
  parameter int PORTS = gpio_pkg::PORT_COUNT // ports bonded
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire gpio_pkg::byte_t sfr_addr, // address
  input wire logic sfr_bit, // bit access
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire gpio_pkg::byte_t sfr_wdata, // write data
  input wire gpio_pkg::byte_t cpu_opcode, // opcode
  input wire logic dbg_active, // debugger interrupt
  input wire logic [7:0] sfr_rdata, // read data
  input wire logic sfr_rvalid, // read answer
  input wire gpio_pkg::port_bus_t port_dir, // direction
  input wire gpio_pkg::port_bus_t pin_in, // pin levels
  input wire gpio_pkg::port_bus_t pin_out, // drive levels
  input wire gpio_pkg::port_bus_t pin_oe_n // drive enables
);
  import gpio_pkg::*;
  logic stl_ff, stall_op, take_n, take_s, wbit;
  logic [6:0] gate_ff, gdly_ff;
  logic [2:0] bsel;
  byte_t p0_out;
  assign stall_op = dbg_active && (cpu_opcode == OP_MOV_DIR_DIR ||
    cpu_opcode == OP_SFR_INDIRECT);
  // A read in the cycle after a stalled read is refused
  assign take_n = sfr_rd && !stl_ff && !stall_op;
  assign take_s = sfr_rd && !stl_ff && stall_op;
  assign bsel = sfr_addr[2:0];
  assign wbit = sfr_wdata[0];
  assign p0_out = pin_out[0];
  always_ff @(posedge clk) begin
    if (srst) stl_ff <= 1'h0;
    else stl_ff <= take_s;
  end
  always_ff @(posedge clk) begin
    if (srst) gate_ff <= 7'h7F;
    else if (sfr_wr && !sfr_bit && sfr_addr == INPUT_GATE_ADDR)
      gate_ff <= sfr_wdata[6:0];
  end
  always_ff @(posedge clk) begin
    if (srst) gdly_ff <= 7'h7F;
    else gdly_ff <= gate_ff;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_read_answer: assert property (take_n |=> sfr_rvalid)
    else $error("plain read not answered in one cycle");
  a_stall_read: assert property (take_s |=> !sfr_rvalid ##1 sfr_rvalid)
    else $error("stalled read not answered in two cycles");
  a_rvalid_cause: assert property (sfr_rvalid |->
    $past(take_n) || $past(take_s, 2))
    else $error("read answer without a read");
  a_reset_idle: assert property (disable iff (1'h0) srst |=>
    pin_out == '1 && pin_oe_n == '1 && !sfr_rvalid)
    else $error("pins not idle inputs after reset");
  a_dir_follow: assert property ((PORTS == PORT_COUNT) && !$past(srst) |->
    pin_oe_n == $past(port_dir))
    else $error("drive enable does not follow direction");
  a_byte_write: assert property (sfr_wr && !sfr_bit &&
    sfr_addr == PORT1_DATA_ADDR |=> pin_out[1] == $past(sfr_wdata))
    else $error("port 1 write not driven");
  a_bit_write: assert property (sfr_wr && sfr_bit &&
    sfr_addr[7:3] == 5'h10 |=> p0_out[$past(bsel)] == $past(wbit))
    else $error("port 0 bit write lost");
  a_rmw_latch: assert property (take_n && !sfr_bit &&
    sfr_addr == PORT0_DATA_ADDR && cpu_opcode == OP_ANL_DIR_IMM |=>
    sfr_rdata == $past(p0_out))
    else $error("logic op read did not see latch");
  a_gated_zero: assert property (take_n && !sfr_bit &&
    sfr_addr == PORT2_DATA_ADDR && cpu_opcode == 8'hE5 && !gate_ff[2] &&
    !gdly_ff[2] |=> sfr_rdata == 8'h00)
    else $error("gated port read not zero");
  a_gate_read: assert property (take_n && !sfr_bit &&
    sfr_addr == INPUT_GATE_ADDR |=> sfr_rdata == {1'h0, $past(gate_ff)})
    else $error("gate register read wrong");
  c_stall: cover property (take_s);
  c_bit_wr: cover property (sfr_wr && sfr_bit);
  c_gated: cover property (take_n && !gate_ff[2] &&
    sfr_addr == PORT2_DATA_ADDR);
endmodule

bind gpio_port_ctrl gpio_port_checker #(.PORTS(PORTS)) chk_u (
  .clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_bit(sfr_bit),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .cpu_opcode(cpu_opcode), .dbg_active(dbg_active), .sfr_rdata(sfr_rdata),
  .sfr_rvalid(sfr_rvalid), .port_dir(port_dir), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ---- verif/board_pins.sv ----
// Board-side pin model: loads follow driven pins, outside sources elsewhere
`timescale 1ns/10ps
module board_pins (
  input wire gpio_pkg::port_bus_t pin_out, // device drive level
  input wire gpio_pkg::port_bus_t pin_oe_n, // low while driven
  input wire gpio_pkg::port_bus_t ext_drv, // outside source level
  output gpio_pkg::port_bus_t pin_in // resolved wire level
);
  import gpio_pkg::*;
  // Push-pull driver wins at both levels over the outside source
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_drv & pin_oe_n);
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the port controller
`timescale 1ns/10ps
module testbench;
  import gpio_pkg::*;
  logic clk, srst, sfr_bit, sfr_wr, sfr_rd, dbg_active, sfr_rvalid;
  byte_t sfr_addr, sfr_wdata, cpu_opcode, rd_data, gate_m;
  logic [7:0] sfr_rdata;
  port_bus_t port_dir, pin_in, pin_out, pin_oe_n, ext_drv;
  int err_total, comparisons, seed, lat;
  logic rvalid5;
  logic [7:0] rdata5;
  port_bus_t pin_out5, oe_n5;
  byte_t rd5_data, pv;
  byte_t latch_m [PORT_COUNT];
  byte_t ops [14] = '{OP_ANL_DIR_IMM, OP_ANL_DIR_A, OP_ORL_DIR_A,
    OP_ORL_DIR_IMM, OP_XRL_DIR_A, OP_XRL_DIR_IMM, OP_JBC_BIT, OP_CPL_BIT,
    OP_INC_DIR, OP_DEC_DIR, OP_DJNZ_DIR, OP_MOV_BIT_C, OP_CLR_BIT,
    OP_SETB_BIT};
  byte_t stall_ops [3] = '{OP_MOV_DIR_DIR, OP_SFR_INDIRECT, 8'hE5};

  gpio_port_ctrl #(.PORTS(PORT_COUNT)) dut_u (.clk(clk), .srst(srst),
    .sfr_addr(sfr_addr), .sfr_bit(sfr_bit), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .cpu_opcode(cpu_opcode),
    .dbg_active(dbg_active), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .port_dir(port_dir), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  board_pins board_u (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_drv(ext_drv), .pin_in(pin_in));
  // Small package: ports 5 and 6 absent, fed from the same pins
  gpio_port_ctrl #(.PORTS(SMALL_PKG_PORTS)) dut5_u (.clk(clk),
    .srst(srst), .sfr_addr(sfr_addr), .sfr_bit(sfr_bit), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .cpu_opcode(cpu_opcode),
    .dbg_active(dbg_active), .sfr_rdata(rdata5), .sfr_rvalid(rvalid5),
    .port_dir(port_dir), .pin_in(pin_in), .pin_out(pin_out5),
    .pin_oe_n(oe_n5));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk8(input string what, input byte_t exp, input byte_t got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chkn(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input byte_t a, input logic b, input byte_t d);
    @(negedge clk);
    sfr_addr = a;
    sfr_bit = b;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    @(negedge clk);
    sfr_wr = 1'h0;
    if (!b && a == INPUT_GATE_ADDR) gate_m = d & 8'h7F;
    for (int p = 0; p < PORT_COUNT; p++) begin
      if (!b && a == PORT_ADDR[p]) latch_m[p] = d;
      if (b && a[7:3] == PORT_ADDR[p][7:3]) latch_m[p][a[2:0]] = d[0];
    end
  endtask

  task automatic rd(input byte_t a, input byte_t op, input logic dbg,
    input logic b = 1'h0);
    @(negedge clk);
    sfr_addr = a;
    sfr_bit = b;
    cpu_opcode = op;
    dbg_active = dbg;
    sfr_rd = 1'h1;
    @(negedge clk);
    sfr_rd = 1'h0;
    lat = 1;
    while (sfr_rvalid !== 1'h1 && lat < 6) begin
      @(negedge clk);
      lat++;
    end
    dbg_active = 1'h0;
    if (lat >= 6) begin
      err_total++;
      final_report();
    end else begin
      rd_data = sfr_rdata;
      rd5_data = (rvalid5 === 1'h1) ? rdata5 : 8'hXX;
    end
  endtask

  function automatic byte_t exp_pin(input int p);
    byte_t v;
    v = (ext_drv[p] & port_dir[p]) | (latch_m[p] & ~port_dir[p]);
    return gate_m[p] ? v : 8'h00;
  endfunction

  task automatic do_reset();
    @(negedge clk);
    srst = 1'h1;
    port_dir = '1;
    repeat (3) @(negedge clk);
    srst = 1'h0;
    gate_m = 8'h7F;
    foreach (latch_m[p]) latch_m[p] = 8'hFF;
    repeat (4) @(negedge clk);
    rd(INPUT_GATE_ADDR, 8'hE5, 1'h0);
    chk8("gate after reset", gate_m, rd_data);
    for (int p = 0; p < PORT_COUNT; p++) begin
      chk8("pin_out after reset", 8'hFF, pin_out[p]);
      chk8("pin_oe_n after reset", 8'hFF, pin_oe_n[p]);
      rd(PORT_ADDR[p], OP_INC_DIR, 1'h0);
      chk8("latch after reset", latch_m[p], rd_data);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {sfr_bit, sfr_wr, sfr_rd, dbg_active} = 4'h0;
    {sfr_addr, sfr_wdata, cpu_opcode} = 24'h0;
    err_total = 0;
    comparisons = 0;
    seed = 32'hdc53;
    srst = 1'h1;
    port_dir = '1;
    ext_drv = '0;
    do_reset();
    // Mixed directions, then every latch-read opcode against the pins
    for (int p = 0; p < PORT_COUNT; p++) begin
      port_dir[p] = byte_t'($random(seed));
      ext_drv[p] = byte_t'($random(seed));
      wr(PORT_ADDR[p], 1'h0, byte_t'($random(seed)));
    end
    for (int b = 0; b < 8; b++) begin
      wr(byte_t'(8'h80 + b), 1'h1, byte_t'($random(seed)));
    end
    repeat (8) @(negedge clk);
    for (int i = 0; i < 14; i++) begin
      chk8("pin_out", latch_m[i % 7], pin_out[i % 7]);
      chk8("pin_oe_n", port_dir[i % 7], pin_oe_n[i % 7]);
      pv = (i % 7 < 5) ? latch_m[i % 7] : 8'hFF;
      chk8("small pin_out", pv, pin_out5[i % 7]);
      pv = (i % 7 < 5) ? port_dir[i % 7] : 8'hFF;
      chk8("small pin_oe_n", pv, oe_n5[i % 7]);
      rd(PORT_ADDR[i % 7], 8'hE5, 1'h0);
      chk8("plain read", exp_pin(i % 7), rd_data);
      pv = (i % 7 < 5) ? exp_pin(i % 7) : 8'h00;
      chk8("small plain read", pv, rd5_data);
      rd(PORT_ADDR[i % 7], ops[i], 1'h0);
      chk8("latch read", latch_m[i % 7], rd_data);
      pv = (i % 7 < 5) ? latch_m[i % 7] : 8'h00;
      chk8("small latch read", pv, rd5_data);
    end
    // Single-bit reads of port 0, latch view then pin view
    for (int b = 0; b < 8; b++) begin
      rd(byte_t'(8'h80 + b), OP_CPL_BIT, 1'h0, 1'h1);
      chk8("bit latch read", {7'h00, latch_m[0][b]}, rd_data);
      rd(byte_t'(8'h80 + b), 8'hE5, 1'h0, 1'h1);
      pv = exp_pin(0);
      chk8("bit pin read", {7'h00, pv[b]}, rd_data);
    end
    // Gate some ports off, then restore with the reserved bit set
    wr(INPUT_GATE_ADDR, 1'h0, byte_t'($random(seed)) & 8'h7B);
    repeat (2) begin
      repeat (8) @(negedge clk);
      rd(INPUT_GATE_ADDR, 8'hE5, 1'h0);
      chk8("gate read", gate_m, rd_data);
      for (int p = 0; p < PORT_COUNT; p++) begin
        rd(PORT_ADDR[p], 8'hE5, 1'h0);
        chk8("gated read", exp_pin(p), rd_data);
      end
      wr(INPUT_GATE_ADDR, 1'h0, 8'hFF);
    end
    // Debugger stall only for the two listed opcodes
    foreach (stall_ops[i]) begin
      rd(PORT0_DATA_ADDR, stall_ops[i], 1'h1);
      chkn("read latency", (i == 2) ? 1 : 2, lat);
      chk8("stalled read", exp_pin(0), rd_data);
    end
    rd(8'h81, 8'hE5, 1'h0);
    chk8("unmapped read", 8'h00, rd_data);
    do_reset();
    final_report();
  end
endmodule
